// ==== eau_pkg.sv ====
// Shared types and constants of the effective-address unit.
// Assumes one system clock; all users import eau_pkg::*.
package eau_pkg;

	// ==========================================================
	// Addressing modes, access sizes, absolute lengths
	typedef enum logic [3:0]
	{
		EAU_M_IND     = 4'h0,
		EAU_M_DISP    = 4'h1,
		EAU_M_POSTINC = 4'h2,
		EAU_M_PREDEC  = 4'h3,
		EAU_M_ABS     = 4'h4,
		EAU_M_IMM     = 4'h5,
		EAU_M_PCREL   = 4'h6,
		EAU_M_MEMIND  = 4'h7,
		EAU_M_BITNUM  = 4'h8,
		EAU_M_TRAP    = 4'h9
	} eau_mode_type;

	typedef enum logic [1:0]
	{
		EAU_SZ_BYTE = 2'h0,
		EAU_SZ_WORD = 2'h1,
		EAU_SZ_LONG = 2'h2
	} eau_size_type;

	typedef enum logic [1:0]
	{
		EAU_LEN_8  = 2'h0,
		EAU_LEN_16 = 2'h1,
		EAU_LEN_24 = 2'h2
	} eau_len_type;

	// ==========================================================
	// Constants
	localparam logic [31:0] EAU_STEP_BYTE  = 32'h0000_0001;
	localparam logic [31:0] EAU_STEP_WORD  = 32'h0000_0002;
	localparam logic [31:0] EAU_STEP_LONG  = 32'h0000_0004;
	localparam logic [15:0] EAU_ABS8_UPPER = 16'hFFFF;
	localparam logic [15:0] EAU_IND_UPPER  = 16'h0000;
	localparam logic [3:0]  EAU_MB1_UPPER  = 4'h0;
	localparam int          EAU_MB1_LSB    = 20;
	localparam logic [23:0] EAU_ADDR_RST   = 24'h000000;
	localparam logic [31:0] EAU_DATA_RST   = 32'h0000_0000;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] eau_step_amt(input eau_size_type sz);
		logic [31:0] r;
		r = EAU_STEP_BYTE;
		if (sz == EAU_SZ_WORD)
			r = EAU_STEP_WORD;
		else if (sz == EAU_SZ_LONG)
			r = EAU_STEP_LONG;
		return r;
	endfunction

	function automatic logic [23:0] eau_final(input logic [23:0] a, input logic even, input logic mb1);
		logic [23:0] r;
		r = a;
		if (even)
			r[0] = 1'b0;
		if (mb1)
			r[23:EAU_MB1_LSB] = EAU_MB1_UPPER;
		return r;
	endfunction

endpackage

// ==== eau_ptr_step.sv ====
// Pointer step for post-increment and pre-decrement.
// Assumes the size code is legal; an illegal code steps by one.
`timescale 1ns/10ps
module eau_ptr_step
	import eau_pkg::*;
(
	input  wire logic [31:0]  i_ptr,
	input  wire eau_size_type i_size,
	input  wire logic         i_dec,
	output logic [31:0]       o_ptr
);

	// ==========================================================
	// Full 32-bit arithmetic; carry past bit 23 is kept
	logic [31:0] amt;

	always_comb
	begin
		amt = eau_step_amt(i_size);
		if (i_dec)
			o_ptr = i_ptr - amt;
		else
			o_ptr = i_ptr + amt;
	end

endmodule

// ==== eau_rel_add.sv ====
// Base plus displacement adder, 24-bit result.
// Assumes the displacement sits in the low bits of i_disp.
`timescale 1ns/10ps
module eau_rel_add
	import eau_pkg::*;
(
	input  wire logic [23:0] i_base,
	input  wire logic [23:0] i_disp,
	input  wire eau_len_type i_len,
	output logic [23:0]      o_sum
);

	// ==========================================================
	// Sign extension by displacement width
	logic [23:0] ext;

	always_comb
	begin
		unique case (i_len)
			EAU_LEN_8:  ext = {{16{i_disp[7]}}, i_disp[7:0]};
			EAU_LEN_16: ext = {{8{i_disp[15]}}, i_disp[15:0]};
			default:    ext = i_disp;
		endcase
		o_sum = i_base + ext;
	end

endmodule

// ==== eau_core.sv ====
// Effective-address unit: forms operand, branch and vector addresses.
// Assumes decoder holds request fields while i_req_valid is high,
// i_pc is the address of the next instruction's first byte.
//
// Operation
// - Post-increment: address is low 24 pointer bits, then pointer grows by size.
// - Post-increment step is 1, 2 or 4 for byte, word, longword.
// - Pre-decrement: pointer shrinks first, stored, low 24 bits address.
// - Pre-decrement step is 1, 2 or 4 for byte, word, longword.
// - 8-bit absolute address gets upper 16 bits all ones.
// - 16-bit absolute address sign-extends bit 15 into upper 8 bits.
// - 24-bit absolute address passes unchanged, reaching whole space.
// - 1-Mbyte modes drop upper 4 address bits, giving 20 bits.
// - Immediate operand of 8, 16 or 32 bits taken from code.
// - Bit instructions decode a 3-bit immediate bit number.
// - Trap instruction's 2-bit field selects its vector address.
// - PC-relative: sign-extend 8/16-bit displacement, add to 24-bit PC.
// - Relative base is next instruction's first byte address.
// - Memory indirect: longword read, first byte dropped, 24-bit target.
// - Memory-indirect pointer address has upper bits zero, lowest 256 bytes.
// - Word, longword (except memory-indirect pointer read) and branch addresses have bit 0 forced to zero.
// - 16-bit register displacement is sign-extended before adding.
`timescale 1ns/10ps
module eau_core
	import eau_pkg::*;
#(
	parameter logic [23:0] TRAP_VEC_BASE = 24'h000020
)
(
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	input  wire logic         i_req_valid,
	input  wire eau_mode_type i_mode,
	input  wire eau_size_type i_size,
	input  wire eau_len_type  i_len,
	input  wire logic [2:0]   i_ptr_sel,
	input  wire logic [31:0]  i_ptr_value,
	input  wire logic [31:0]  i_ext,
	input  wire logic [2:0]   i_op_field,
	input  wire logic [23:0]  i_pc,
	input  wire logic         i_mode_1mb,
	input  wire logic         i_acc_ready,
	input  wire logic         i_rd_valid,
	input  wire logic [31:0]  i_rd_data,
	output logic              o_req_ready,
	output logic              o_acc_valid,
	output logic [23:0]       o_acc_addr,
	output eau_size_type      o_acc_size,
	output logic              o_acc_ind,
	output logic              o_wb_valid,
	output logic [2:0]        o_wb_sel,
	output logic [31:0]       o_wb_value,
	output logic              o_imm_valid,
	output logic [31:0]       o_imm_value,
	output logic              o_bit_valid,
	output logic [2:0]        o_bit_num,
	output logic              o_vec_valid,
	output logic [23:0]       o_vec_addr,
	output logic              o_tgt_valid,
	output logic [23:0]       o_tgt_addr
);

	// ==========================================================
	// State
	typedef enum logic [1:0]
	{
		EAU_ST_IDLE   = 2'b00,
		EAU_ST_ACCESS = 2'b01,
		EAU_ST_INDRD  = 2'b10
	} eau_state_type;

	eau_state_type state;
	eau_state_type next_state;
	logic          wb_pend;
	logic          next_wb_pend;
	logic          ind_mb;
	logic          next_ind_mb;
	logic          next_req_ready;
	logic          next_acc_valid;
	logic [23:0]   next_acc_addr;
	eau_size_type  next_acc_size;
	logic          next_acc_ind;
	logic          next_wb_valid;
	logic [2:0]    next_wb_sel;
	logic [31:0]   next_wb_value;
	logic          next_imm_valid;
	logic [31:0]   next_imm_value;
	logic          next_bit_valid;
	logic [2:0]    next_bit_num;
	logic          next_vec_valid;
	logic [23:0]   next_vec_addr;
	logic          next_tgt_valid;
	logic [23:0]   next_tgt_addr;
	logic          take;
	logic          acc_taken;
	logic          even;
	logic [31:0]   step_ptr;
	logic [23:0]   pc_sum;
	logic [23:0]   disp_sum;
	logic [23:0]   abs_addr;

	assign take      = i_req_valid && o_req_ready;
	assign acc_taken = o_acc_valid && i_acc_ready;
	assign even      = (i_size != EAU_SZ_BYTE);

	// ==========================================================
	// Arithmetic
	eau_ptr_step u_step
	(
		.i_ptr  (i_ptr_value),
		.i_size (i_size),
		.i_dec  (i_mode == EAU_M_PREDEC),
		.o_ptr  (step_ptr)
	);

	eau_rel_add u_pcrel
	(
		.i_base (i_pc),
		.i_disp (i_ext[23:0]),
		.i_len  (i_len),
		.o_sum  (pc_sum)
	);

	// Displacement mode allows 16 or 24 bits only
	eau_rel_add u_disp
	(
		.i_base (i_ptr_value[23:0]),
		.i_disp (i_ext[23:0]),
		.i_len  ((i_len == EAU_LEN_16) ? EAU_LEN_16 : EAU_LEN_24),
		.o_sum  (disp_sum)
	);

	always_comb
	begin
		unique case (i_len)
			EAU_LEN_8:  abs_addr = {EAU_ABS8_UPPER, i_ext[7:0]};
			EAU_LEN_16: abs_addr = {{8{i_ext[15]}}, i_ext[15:0]};
			default:    abs_addr = i_ext[23:0];
		endcase
	end

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		next_state     = state;
		next_wb_pend   = wb_pend;
		next_ind_mb    = ind_mb;
		next_req_ready = o_req_ready;
		next_acc_valid = o_acc_valid;
		next_acc_addr  = o_acc_addr;
		next_acc_size  = o_acc_size;
		next_acc_ind   = o_acc_ind;
		next_wb_valid  = 1'b0;
		next_wb_sel    = o_wb_sel;
		next_wb_value  = o_wb_value;
		next_imm_valid = 1'b0;
		next_imm_value = o_imm_value;
		next_bit_valid = 1'b0;
		next_bit_num   = o_bit_num;
		next_vec_valid = 1'b0;
		next_vec_addr  = o_vec_addr;
		next_tgt_valid = 1'b0;
		next_tgt_addr  = o_tgt_addr;
		unique case (state)
			EAU_ST_IDLE:
			begin
				if (take)
				begin
					next_acc_size = i_size;
					next_acc_ind  = 1'b0;
					next_wb_pend  = 1'b0;
					next_wb_sel   = i_ptr_sel;
					next_wb_value = step_ptr;
					// Decoder may move on after take; indirect target keeps this mode
					next_ind_mb   = i_mode_1mb;
					unique case (i_mode)
						EAU_M_IND, EAU_M_DISP, EAU_M_POSTINC, EAU_M_PREDEC, EAU_M_ABS:
						begin
							next_state     = EAU_ST_ACCESS;
							next_req_ready = 1'b0;
							next_acc_valid = 1'b1;
							if (i_mode == EAU_M_DISP)
								next_acc_addr = eau_final(disp_sum, even, i_mode_1mb);
							else if (i_mode == EAU_M_PREDEC)
								next_acc_addr = eau_final(step_ptr[23:0], even, i_mode_1mb);
							else if (i_mode == EAU_M_ABS)
								next_acc_addr = eau_final(abs_addr, even, i_mode_1mb);
							else
								next_acc_addr = eau_final(i_ptr_value[23:0], even, i_mode_1mb);
							next_wb_pend = (i_mode == EAU_M_POSTINC) || (i_mode == EAU_M_PREDEC);
						end
						EAU_M_MEMIND:
						begin
							next_state     = EAU_ST_ACCESS;
							next_req_ready = 1'b0;
							next_acc_valid = 1'b1;
							next_acc_size  = EAU_SZ_LONG;
							next_acc_ind   = 1'b1;
							next_acc_addr  = {EAU_IND_UPPER, i_ext[7:0]};
						end
						EAU_M_IMM:
						begin
							next_imm_valid = 1'b1;
							unique case (i_size)
								EAU_SZ_BYTE: next_imm_value = {24'h000000, i_ext[7:0]};
								EAU_SZ_WORD: next_imm_value = {16'h0000, i_ext[15:0]};
								default:     next_imm_value = i_ext;
							endcase
						end
						EAU_M_PCREL:
						begin
							next_tgt_valid = 1'b1;
							next_tgt_addr  = eau_final(pc_sum, 1'b1, i_mode_1mb);
						end
						EAU_M_BITNUM:
						begin
							next_bit_valid = 1'b1;
							next_bit_num   = i_op_field;
						end
						EAU_M_TRAP:
						begin
							next_vec_valid = 1'b1;
							next_vec_addr  = eau_final(TRAP_VEC_BASE + {20'h00000, i_op_field[1:0], 2'h0},
								1'b1, i_mode_1mb);
						end
						default:
						begin
							next_imm_valid = 1'b0;
						end
					endcase
				end
			end
			EAU_ST_ACCESS:
			begin
				if (acc_taken)
				begin
					next_acc_valid = 1'b0;
					next_acc_ind   = 1'b0;
					next_wb_valid  = wb_pend;
					next_wb_pend   = 1'b0;
					if (o_acc_ind)
						next_state = EAU_ST_INDRD;
					else
					begin
						next_state     = EAU_ST_IDLE;
						next_req_ready = 1'b1;
					end
				end
			end
			EAU_ST_INDRD:
			begin
				// Top byte of the fetched longword is ignored
				if (i_rd_valid)
				begin
					next_tgt_valid = 1'b1;
					next_tgt_addr  = eau_final(i_rd_data[23:0], 1'b1, ind_mb);
					next_state     = EAU_ST_IDLE;
					next_req_ready = 1'b1;
				end
			end
			default:
			begin
				next_state     = EAU_ST_IDLE;
				next_req_ready = 1'b1;
				next_acc_valid = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			state       <= EAU_ST_IDLE;
			wb_pend     <= 1'b0;
			ind_mb      <= 1'b0;
			o_req_ready <= 1'b1;
			o_acc_valid <= 1'b0;
			o_acc_addr  <= EAU_ADDR_RST;
			o_acc_size  <= EAU_SZ_BYTE;
			o_acc_ind   <= 1'b0;
			o_wb_valid  <= 1'b0;
			o_wb_sel    <= 3'h0;
			o_wb_value  <= EAU_DATA_RST;
			o_imm_valid <= 1'b0;
			o_imm_value <= EAU_DATA_RST;
			o_bit_valid <= 1'b0;
			o_bit_num   <= 3'h0;
			o_vec_valid <= 1'b0;
			o_vec_addr  <= EAU_ADDR_RST;
			o_tgt_valid <= 1'b0;
			o_tgt_addr  <= EAU_ADDR_RST;
		end
		else
		begin
			state       <= next_state;
			wb_pend     <= next_wb_pend;
			ind_mb      <= next_ind_mb;
			o_req_ready <= next_req_ready;
			o_acc_valid <= next_acc_valid;
			o_acc_addr  <= next_acc_addr;
			o_acc_size  <= next_acc_size;
			o_acc_ind   <= next_acc_ind;
			o_wb_valid  <= next_wb_valid;
			o_wb_sel    <= next_wb_sel;
			o_wb_value  <= next_wb_value;
			o_imm_valid <= next_imm_valid;
			o_imm_value <= next_imm_value;
			o_bit_valid <= next_bit_valid;
			o_bit_num   <= next_bit_num;
			o_vec_valid <= next_vec_valid;
			o_vec_addr  <= next_vec_addr;
			o_tgt_valid <= next_tgt_valid;
			o_tgt_addr  <= next_tgt_addr;
		end
	end

	// ==========================================================
	// Checks
	logic [31:0]  h_ptr;
	logic [31:0]  h_ext;
	logic [23:0]  h_pc;
	eau_size_type h_size;
	eau_mode_type h_mode;
	logic         h_mb;
	logic [31:0]  h_dec;
	logic [23:0]  h_rel8;

	always_ff @(posedge i_clock)
	begin
		if (take)
		begin
			h_ptr  <= i_ptr_value;
			h_ext  <= i_ext;
			h_pc   <= i_pc;
			h_size <= i_size;
			h_mode <= i_mode;
			h_mb   <= i_mode_1mb;
		end
	end

	assign h_dec  = h_ptr - eau_step_amt(h_size);
	assign h_rel8 = h_pc + {{16{h_ext[7]}}, h_ext[7:0]};

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	sequence s_take(eau_mode_type m);
		take && (i_mode == m);
	endsequence

	sequence s_accept;
		o_acc_valid && i_acc_ready;
	endsequence

	property p_post_addr;
		s_take(EAU_M_POSTINC) |=> o_acc_valid && (o_acc_addr[19:1] == h_ptr[19:1]);
	endproperty
	a_post_addr: assert property (p_post_addr) else $error("post-increment address wrong");

	property p_post_wb;
		s_accept and (wb_pend && h_mode == EAU_M_POSTINC) |=>
			o_wb_valid && (o_wb_value == h_ptr + eau_step_amt(h_size));
	endproperty
	a_post_wb: assert property (p_post_wb) else $error("post-increment write-back wrong");

	property p_pre;
		s_take(EAU_M_PREDEC) |=> (o_acc_addr[19:1] == h_dec[19:1]) && (o_wb_value == h_dec);
	endproperty
	a_pre: assert property (p_pre) else $error("pre-decrement result wrong");

	property p_abs8;
		s_take(EAU_M_ABS) and (i_len == EAU_LEN_8) |=> o_acc_addr[15:8] == 8'hFF;
	endproperty
	a_abs8: assert property (p_abs8) else $error("short absolute upper bits not ones");

	property p_abs16;
		s_take(EAU_M_ABS) and (i_len == EAU_LEN_16) && !i_mode_1mb |=> o_acc_addr[23:16] == {8{h_ext[15]}};
	endproperty
	a_abs16: assert property (p_abs16) else $error("16-bit absolute not sign extended");

	property p_mb1;
		h_mb && (o_acc_valid || o_tgt_valid) |->
			(!o_acc_valid || (o_acc_addr[23:20] == 4'h0)) && (!o_tgt_valid || (o_tgt_addr[23:20] == 4'h0));
	endproperty
	a_mb1: assert property (p_mb1) else $error("upper bits kept in 1-Mbyte mode");

	property p_even;
		o_acc_valid && (o_acc_size != EAU_SZ_BYTE) |-> !o_acc_addr[0];
	endproperty
	a_even: assert property (p_even) else $error("odd word address presented");

	property p_wb_after;
		o_wb_valid |-> $past(acc_taken);
	endproperty
	a_wb_after: assert property (p_wb_after) else $error("write-back before access accepted");

	property p_rel8;
		s_take(EAU_M_PCREL) and (i_len == EAU_LEN_8) && !i_mode_1mb |=>
			o_tgt_valid && (o_tgt_addr == {h_rel8[23:1], 1'b0});
	endproperty
	a_rel8: assert property (p_rel8) else $error("relative target wrong");

	property p_ind;
		s_take(EAU_M_MEMIND) |=> o_acc_ind && (o_acc_size == EAU_SZ_LONG) && (o_acc_addr[23:8] == 16'h0000);
	endproperty
	a_ind: assert property (p_ind) else $error("indirect pointer access wrong");

	property p_bit;
		s_take(EAU_M_BITNUM) |=> o_bit_valid && (o_bit_num == $past(i_op_field));
	endproperty
	a_bit: assert property (p_bit) else $error("bit number wrong");

endmodule

// ==== eau_bus_model.sv ====
// Bus controller model facing the effective-address unit.
// Assumes eau_core request/accept handshake; the seed is set by the bench.
`timescale 1ns/10ps
module eau_bus_model
	import eau_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_acc_valid,
	input  wire logic        i_acc_ind,
	input  wire logic [23:0] i_acc_addr,
	output logic             o_acc_ready,
	output logic             o_rd_valid,
	output logic [31:0]      o_rd_data
);
	int          wait_cnt;
	int          rd_cnt;
	logic [23:0] rd_addr;

	// ==========================================================
	// Memory contents: low bit set so target rounding shows
	function automatic logic [31:0] mem_word(input logic [23:0] a);
		return {~a[7:0], a[7:0] ^ 8'h5A, 8'h3C, a[7:0] | 8'h01};
	endfunction

	// ==========================================================
	// Accept after 0 to 3 cycles, answer indirect reads later
	always @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_acc_ready <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= 32'h0;
			wait_cnt <= 0;
			rd_cnt <= 0;
		end
		else
		begin
			o_rd_valid <= 1'b0;
			// Released data lines do not keep the last value
			o_rd_data <= ~o_rd_data;
			if (o_acc_ready && i_acc_valid)
			begin
				o_acc_ready <= 1'b0;
				if (i_acc_ind)
				begin
					rd_cnt <= 1 + $urandom_range(3);
					rd_addr <= i_acc_addr;
				end
			end
			else if (i_acc_valid && wait_cnt == 0)
			begin
				o_acc_ready <= 1'b1;
				wait_cnt <= $urandom_range(3);
			end
			else if (i_acc_valid)
				wait_cnt <= wait_cnt - 1;
			if (rd_cnt == 1)
			begin
				o_rd_valid <= 1'b1;
				o_rd_data <= mem_word(rd_addr);
			end
			if (rd_cnt > 0)
				rd_cnt <= rd_cnt - 1;
		end
	end
endmodule

// ==== cpu_effective_address_unit_test.sv ====
// Self-checking bench for eau_core with a bus controller model.
// Assumes 200 MHz clock; results are checked against queued notes.
`timescale 1ns/10ps
module cpu_effective_address_unit_test
	import eau_pkg::*;
;
	localparam logic [23:0] TVB = 24'h000100;

	logic         i_clock = 1'b0;
	logic         i_rst = 1'b1;
	logic         i_req_valid = 1'b0;
	eau_mode_type i_mode = EAU_M_IND;
	eau_size_type i_size = EAU_SZ_BYTE;
	eau_len_type  i_len = EAU_LEN_8;
	logic [2:0]   i_ptr_sel = 3'h0;
	logic [31:0]  i_ptr_value = 32'h0;
	logic [31:0]  i_ext = 32'h0;
	logic [2:0]   i_op_field = 3'h0;
	logic [23:0]  i_pc = 24'h0;
	logic         i_mode_1mb = 1'b0;
	logic         i_acc_ready, i_rd_valid, o_req_ready, o_acc_valid, o_acc_ind, o_wb_valid;
	logic         o_imm_valid, o_bit_valid, o_vec_valid, o_tgt_valid;
	logic [31:0]  i_rd_data, o_wb_value, o_imm_value;
	logic [23:0]  o_acc_addr, o_vec_addr, o_tgt_addr;
	logic [2:0]   o_wb_sel, o_bit_num;
	eau_size_type o_acc_size;
	logic [63:0]  q_acc[$], q_wb[$], q_imm[$], q_bit[$], q_vec[$], q_tgt[$];
	int           err_count = 0;
	int           checked = 0;

	always #2.5 i_clock = ~i_clock;

	eau_core #(.TRAP_VEC_BASE(TVB)) uut (.i_clock(i_clock), .i_rst(i_rst), .i_req_valid(i_req_valid),
		.i_mode(i_mode), .i_size(i_size), .i_len(i_len), .i_ptr_sel(i_ptr_sel), .i_ptr_value(i_ptr_value),
		.i_ext(i_ext), .i_op_field(i_op_field), .i_pc(i_pc), .i_mode_1mb(i_mode_1mb),
		.i_acc_ready(i_acc_ready), .i_rd_valid(i_rd_valid), .i_rd_data(i_rd_data), .o_req_ready(o_req_ready),
		.o_acc_valid(o_acc_valid), .o_acc_addr(o_acc_addr), .o_acc_size(o_acc_size), .o_acc_ind(o_acc_ind),
		.o_wb_valid(o_wb_valid), .o_wb_sel(o_wb_sel), .o_wb_value(o_wb_value), .o_imm_valid(o_imm_valid),
		.o_imm_value(o_imm_value), .o_bit_valid(o_bit_valid), .o_bit_num(o_bit_num),
		.o_vec_valid(o_vec_valid), .o_vec_addr(o_vec_addr), .o_tgt_valid(o_tgt_valid), .o_tgt_addr(o_tgt_addr));

	eau_bus_model bus (.i_clock(i_clock), .i_rst(i_rst), .i_acc_valid(o_acc_valid), .i_acc_ind(o_acc_ind),
		.i_acc_addr(o_acc_addr), .o_acc_ready(i_acc_ready), .o_rd_valid(i_rd_valid), .o_rd_data(i_rd_data));

	// ==========================================================
	// Comparison and verdict
	task automatic test_done;
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_acc(input logic [26:0] g, input logic [63:0] e);
		cmp({37'h0, g}, e);
	endtask

	task automatic cmp_wb(input logic [34:0] g, input logic [63:0] e);
		cmp({29'h0, g}, e);
	endtask

	task automatic cmp_imm(input logic [31:0] g, input logic [63:0] e);
		cmp({32'h0, g}, e);
	endtask

	task automatic cmp_bit(input logic [2:0] g, input logic [63:0] e);
		cmp({61'h0, g}, e);
	endtask

	task automatic cmp_vec(input logic [23:0] g, input logic [63:0] e);
		cmp({40'h0, g}, e);
	endtask

	task automatic cmp_tgt(input logic [23:0] g, input logic [63:0] e);
		cmp({40'h0, g}, e);
	endtask

	function automatic logic [23:0] fin(input logic [23:0] a, input logic ev, input logic mb);
		logic [23:0] r;
		r = a;
		if (ev)
			r[0] = 1'b0;
		if (mb)
			r[23:20] = 4'h0;
		return r;
	endfunction

	// ==========================================================
	// Driver: called just after a rising edge, leaves request up
	task automatic req(input eau_mode_type m, input eau_size_type sz, input eau_len_type ln,
		input logic [31:0] p, input logic [31:0] e, input logic [2:0] op, input logic [23:0] pc,
		input logic mb);
		logic [31:0] st;
		logic [31:0] nv;
		logic [23:0] d;
		logic [2:0]  sel;
		logic        ev;
		logic [31:0] mw;
		sel = 3'($urandom_range(7));
		st = (sz == EAU_SZ_BYTE) ? 32'h1 : (sz == EAU_SZ_WORD) ? 32'h2 : 32'h4;
		ev = (sz != EAU_SZ_BYTE);
		nv = p - st;
		d = (ln == EAU_LEN_8) ? {{16{e[7]}}, e[7:0]} : {{8{e[15]}}, e[15:0]};
		case (m)
			EAU_M_POSTINC:
			begin
				q_acc.push_back({1'b0, sz, fin(p[23:0], ev, mb)});
				q_wb.push_back({sel, p + st});
			end
			EAU_M_PREDEC:
			begin
				q_acc.push_back({1'b0, sz, fin(nv[23:0], ev, mb)});
				q_wb.push_back({sel, nv});
			end
			EAU_M_IND: q_acc.push_back({1'b0, sz, fin(p[23:0], ev, mb)});
			EAU_M_DISP: q_acc.push_back({1'b0, sz, fin(p[23:0] + ((ln == EAU_LEN_16) ?
				{{8{e[15]}}, e[15:0]} : e[23:0]), ev, mb)});
			EAU_M_ABS: q_acc.push_back({1'b0, sz, fin((ln == EAU_LEN_8) ? {16'hFFFF, e[7:0]} :
				(ln == EAU_LEN_16) ? {{8{e[15]}}, e[15:0]} : e[23:0], ev, mb)});
			EAU_M_IMM: q_imm.push_back((sz == EAU_SZ_BYTE) ? {56'h0, e[7:0]} :
				(sz == EAU_SZ_WORD) ? {48'h0, e[15:0]} : {32'h0, e});
			EAU_M_BITNUM: q_bit.push_back({61'h0, op});
			EAU_M_TRAP: q_vec.push_back({40'h0, TVB + {op[1:0], 2'b00}});
			EAU_M_PCREL: q_tgt.push_back({40'h0, fin(pc + d, 1'b1, mb)});
			EAU_M_MEMIND:
			begin
				q_acc.push_back({1'b1, EAU_SZ_LONG, 16'h0000, e[7:0]});
				mw = bus.mem_word({16'h0000, e[7:0]});
				q_tgt.push_back({40'h0, fin(mw[23:0], 1'b1, mb)});
			end
			default: ;
		endcase
		i_req_valid <= 1'b1;
		i_mode <= m;
		i_size <= sz;
		i_len <= ln;
		i_ptr_sel <= sel;
		i_ptr_value <= p;
		i_ext <= e;
		i_op_field <= op;
		i_pc <= pc;
		i_mode_1mb <= mb;
		@(negedge i_clock);
		for (int k = 0; k < 100 && o_req_ready !== 1'b1; k++)
			@(negedge i_clock);
		if (o_req_ready !== 1'b1)
			err_count++;
		@(posedge i_clock);
	endtask

	// ==========================================================
	// Observer: results sampled mid-cycle, oldest note first
	always @(negedge i_clock)
	begin
		if (!i_rst)
		begin
			if (o_acc_valid === 1'b1 && i_acc_ready === 1'b1)
				cmp_acc({o_acc_ind, o_acc_size, o_acc_addr}, q_acc.size() ? q_acc.pop_front() : ~64'h0);
			if (o_wb_valid === 1'b1)
				cmp_wb({o_wb_sel, o_wb_value}, q_wb.size() ? q_wb.pop_front() : ~64'h0);
			if (o_imm_valid === 1'b1)
				cmp_imm(o_imm_value, q_imm.size() ? q_imm.pop_front() : ~64'h0);
			if (o_bit_valid === 1'b1)
				cmp_bit(o_bit_num, q_bit.size() ? q_bit.pop_front() : ~64'h0);
			if (o_vec_valid === 1'b1)
				cmp_vec(o_vec_addr, q_vec.size() ? q_vec.pop_front() : ~64'h0);
			if (o_tgt_valid === 1'b1)
				cmp_tgt(o_tgt_addr, q_tgt.size() ? q_tgt.pop_front() : ~64'h0);
		end
	end

	initial
	begin
		#100000;
		err_count++;
		test_done;
	end

	// ==========================================================
	// Scenarios
	initial
	begin
		logic [31:0] p;
		logic [31:0] pe[6];
		void'($urandom(80));
		pe = '{32'h80, 32'h7F, 32'h01, 32'h8000, 32'h7FFF, $urandom};
		repeat (16) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		for (int s = 0; s < 3; s++)
			for (int k = 0; k < 4; k++)
			begin
				p = (k == 0) ? 32'h00FF_FFFF : (k == 1) ? 32'h0 : $urandom;
				req(EAU_M_POSTINC, eau_size_type'(s), EAU_LEN_24, p, 32'h0, 3'h0, 24'h0, k[1]);
				req(EAU_M_PREDEC, eau_size_type'(s), EAU_LEN_24, p, 32'h0, 3'h0, 24'h0, k[0]);
			end
		for (int s = 0; s < 3; s++)
			for (int l = 0; l < 6; l++)
				req(EAU_M_ABS, eau_size_type'(s), eau_len_type'(l % 3), $urandom, $urandom, 3'h0, 24'h0,
					l > 2);
		for (int k = 0; k < 4; k++)
		begin
			req(EAU_M_IND, eau_size_type'(k % 3), EAU_LEN_24, $urandom, 32'h0, 3'h0, 24'h0, k[0]);
			req(EAU_M_DISP, EAU_SZ_WORD, k[0] ? EAU_LEN_16 : EAU_LEN_24, $urandom, $urandom, 3'h0, 24'h0,
				1'b0);
		end
		for (int k = 0; k < 6; k++)
			req(EAU_M_IMM, eau_size_type'(k % 3), EAU_LEN_24, 32'h0, $urandom, 3'h0, 24'h0, 1'b0);
		for (int k = 0; k < 8; k++)
			req(EAU_M_BITNUM, EAU_SZ_BYTE, EAU_LEN_8, 32'h0, 32'h0, 3'(k), 24'h0, 1'b0);
		for (int k = 0; k < 4; k++)
			req(EAU_M_TRAP, EAU_SZ_BYTE, EAU_LEN_8, 32'h0, 32'h0, 3'(k), 24'h0, 1'b0);
		for (int k = 0; k < 6; k++)
			req(EAU_M_PCREL, EAU_SZ_BYTE, (k < 3) ? EAU_LEN_8 : EAU_LEN_16, 32'h0, pe[k], 3'h0,
				24'($urandom), k == 5);
		for (int k = 0; k < 3; k++)
			req(EAU_M_MEMIND, EAU_SZ_LONG, EAU_LEN_8, 32'h0, $urandom & 32'hFE, 3'h0, 24'h0, k == 2);
		i_req_valid <= 1'b0;
		repeat (30) @(posedge i_clock);
		cmp(q_acc.size() + q_wb.size() + q_imm.size() + q_bit.size() + q_vec.size() + q_tgt.size(), 64'h0);
		test_done;
	end
endmodule
